// >>> bench/sdl_ser_model.sv
`timescale 1ns/100ps
module sdl_ser_model
  import sdl_pkg::*;
(
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // training requests
  input  wire logic                 training_request_a,
  input  wire logic                 training_request_b,
  // word source
  input  wire logic [WORD_BITS-1:0] tx_word,
  input  wire logic                 bad_clock,
  // serial side
  output logic                      serial_in_pos,
  output logic                      serial_in_neg,
  output logic                      frame_start,
  output logic                      sync_busy
);
  // ****************
  // framing
  // ****************
  // six ones then six zeros: only the true phase shows a valid clock pair
  localparam logic [WORD_BITS-1:0] SYNC_WORD = 10'h3E0;
  localparam logic [10:0]          SYNC_MIN  = 11'h400;
  logic [3:0]            pos_ff;
  logic [FRAME_BITS-1:0] frame_ff;
  logic [10:0]           sync_cnt_ff;
  logic                  req;
  logic [WORD_BITS-1:0]  load_word;
  assign req = training_request_a | training_request_b;
  // frame count runs on after request drops, so a short pulse still trains
  assign sync_busy = req | (sync_cnt_ff != 11'h0);
  assign load_word = sync_busy ? SYNC_WORD : tx_word;
  assign frame_start = (pos_ff == LAST_BIT);
  assign serial_in_pos = frame_ff[FRAME_BITS-1];
  assign serial_in_neg = ~frame_ff[FRAME_BITS-1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_ff <= 4'h0;
      frame_ff <= '0;
      sync_cnt_ff <= 11'h0;
    end else begin
      pos_ff <= frame_start ? 4'h0 : pos_ff + 4'h1;
      // clock bit 1, data msb first, clock bit 0; bad swaps them
      frame_ff <= frame_start ? {~bad_clock, load_word, bad_clock} : frame_ff << 1;
      sync_cnt_ff <= req ? SYNC_MIN : sync_cnt_ff - {10'h0, frame_start && sync_cnt_ff != 11'h0};
    end
  end
endmodule

// >>> bench/serial_deserializer_lock_output_ctrl_test.sv
`timescale 1ns/100ps
module serial_deserializer_lock_output_ctrl_test
  import sdl_pkg::*;
;
  logic                 hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0]          haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [1:0]           htrans = 2'h0;
  logic [2:0]           hsize = HSIZE_WORD;
  logic                 ref_clk = 1'b0, ref_run = 1'b0, sleep_n = 1'b1, sel = 1'b1;
  logic                 bad = 1'b0, fb_en = 1'b1, edge_chk = 1'b0;
  logic [WORD_BITS-1:0] tx_word = 10'h0, w, prev_word, word_out;
  logic                 hready, hresp, pos, neg, fstart, busy, req_a;
  logic                 rclk, rclk_oe_n, word_oe_n, lock_n, lock_oe_n;
  int                   error_cnt = 0, compares = 0;

  // lock indicator drives the training request
  assign req_a = lock_n & fb_en;
  always #5 hclk = ~hclk;
  always #50 if (ref_run) ref_clk = ~ref_clk;

  sdl_deser dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .serial_in_pos(pos), .serial_in_neg(neg),
    .local_reference_clock(ref_clk), .sleep_n(sleep_n), .out_edge_select(sel),
    .parallel_word_out(word_out), .word_oe_n(word_oe_n), .recovered_clock(rclk),
    .recovered_clock_oe_n(rclk_oe_n), .lock_n(lock_n), .lock_oe_n(lock_oe_n));
  sdl_ser_model ser (.hclk(hclk), .hresetn(hresetn), .training_request_a(req_a),
    .training_request_b(1'b0), .tx_word(tx_word), .bad_clock(bad), .serial_in_pos(pos),
    .serial_in_neg(neg), .frame_start(fstart), .sync_busy(busy));

  // ****************
  // tasks
  // ****************
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // values set here go into the frame loaded at the next boundary
  task frames(input int n, input logic b, input logic [WORD_BITS-1:0] v);
    repeat (n) begin
      @(posedge hclk);
      while (fstart !== 1'b1) @(posedge hclk);
      tx_word <= v;
      bad <= b;
    end
  endtask
  task wait_lock();
    for (int i = 0; i < 300 && lock_n !== 1'b0; i++) frames(1, 1'b0, 10'($urandom));
    chk("lock_n", 32'(lock_n), 32'h0);
  endtask
  task settle();
    repeat (3) @(posedge hclk);
  endtask
  task endt(input string s);
    $display("test %s done", s);
  endtask
  task give_verdict();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // a word change must land on the edge away from the strobe edge
  always @(posedge hclk) begin
    if (edge_chk && word_out !== prev_word) chk("edge", 32'(rclk), 32'(!sel));
    prev_word = word_out;
  end

  initial begin
    #600000;
    error_cnt++;
    give_verdict();
  end

  // ****************
  // sequence
  // ****************
  initial begin
    rd = $urandom(94414);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk("lock_n", 32'(lock_n), 32'h1);
    chk("lock_oe_n", 32'(lock_oe_n), 32'h0);
    ahb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h1);
    chk("hresp", 32'(hresp), 32'h0);
    ahb(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    endt("reset");
    frames(30, 1'b0, 10'h0);
    chk("lock_n", 32'(lock_n), 32'h1);
    chk("word_oe_n", 32'(word_oe_n), 32'h1);
    chk("rclk_oe_n", 32'(rclk_oe_n), 32'h1);
    chk("rclk", 32'(rclk), 32'h0);
    endt("no reference");
    ref_run <= 1'b1;
    wait_lock();
    settle();
    chk("word_oe_n", 32'(word_oe_n), 32'h0);
    while (busy !== 1'b0) @(posedge hclk);
    ahb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rd & 32'h17, 32'h15);
    endt("sync lock");
    for (int i = 0; i < 6; i++) begin
      w = (i < 2) ? {10{i[0]}} : 10'($urandom);
      edge_chk <= 1'b0;
      sel <= i[0];
      frames(1, 1'b0, w);
      edge_chk <= 1'b1;
      frames(4, 1'b0, w);
      chk("word", 32'(word_out), 32'(w));
      ahb(1'b0, STATUS_OFS, 32'h0);
      chk("last word", 32'(rd[25:16]), 32'(w));
    end
    edge_chk <= 1'b0;
    endt("words");
    ahb(1'b1, CTRL_OFS, 32'h0);
    settle();
    chk("word_oe_n", 32'(word_oe_n), 32'h1);
    chk("rclk_oe_n", 32'(rclk_oe_n), 32'h1);
    chk("lock_n", 32'(lock_n), 32'h0);
    chk("lock_oe_n", 32'(lock_oe_n), 32'h0);
    ahb(1'b1, CTRL_OFS, 32'h1);
    settle();
    chk("word_oe_n", 32'(word_oe_n), 32'h0);
    endt("enable");
    frames(3, 1'b1, 10'h155);
    frames(4, 1'b0, 10'h155);
    chk("lock_n", 32'(lock_n), 32'h0);
    frames(4, 1'b1, 10'h2AA);
    frames(4, 1'b0, 10'h2AA);
    chk("lock_n", 32'(lock_n), 32'h1);
    chk("word_oe_n", 32'(word_oe_n), 32'h1);
    wait_lock();
    ahb(1'b0, LOSS_OFS, 32'h0);
    chk("loss count", rd, 32'h1);
    while (busy !== 1'b0) @(posedge hclk);
    // words from before the loss are suspect; only fresh frames are compared
    frames(5, 1'b0, 10'h0F0);
    chk("relock word", 32'(word_out), 32'h0F0);
    endt("loss");
    fb_en <= 1'b0;
    ahb(1'b1, CTRL_OFS, 32'h3);
    settle();
    chk("lock_n", 32'(lock_n), 32'h1);
    wait_lock();
    endt("random lock");
    ref_run <= 1'b0;
    repeat (120) @(posedge hclk);
    chk("lock_n", 32'(lock_n), 32'h1);
    chk("rclk", 32'(rclk), 32'h0);
    ref_run <= 1'b1;
    endt("reference loss");
    sleep_n <= 1'b0;
    settle();
    chk("lock_oe_n", 32'(lock_oe_n), 32'h1);
    chk("word_oe_n", 32'(word_oe_n), 32'h1);
    chk("rclk_oe_n", 32'(rclk_oe_n), 32'h1);
    sleep_n <= 1'b1;
    fb_en <= 1'b1;
    wait_lock();
    endt("sleep");
    give_verdict();
  end
endmodule

// >>> verilog/sdl_deser.sv
`timescale 1ns/100ps
module sdl_deser
  import sdl_pkg::*;
(
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // register bus
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // serial link
  input  wire logic                 serial_in_pos,
  input  wire logic                 serial_in_neg,
  input  wire logic                 local_reference_clock,
  // control pins
  input  wire logic                 sleep_n,
  input  wire logic                 out_edge_select,
  // parallel side
  output logic [WORD_BITS-1:0]      parallel_word_out,
  output logic                      word_oe_n,
  output logic                      recovered_clock,
  output logic                      recovered_clock_oe_n,
  output logic                      lock_n,
  output logic                      lock_oe_n
);

  // ****************************************
  // declarations
  // ****************************************
  sdl_state_t            state_ff;
  sdl_state_t            nxt_state;
  logic [3:0]            good_ff;
  logic [3:0]            nxt_good;
  logic [2:0]            bad_ff;
  logic [2:0]            nxt_bad;
  logic                  slip;
  logic                  ref_ok;
  logic                  serial_bit;
  logic                  rehunt_ff;
  logic                  out_en_ff;
  logic [15:0]           loss_cnt_ff;
  logic [WORD_BITS-1:0]  pend_ff;
  logic [WORD_BITS-1:0]  pword_ff;
  logic                  rclk_ff;
  logic                  word_oe_n_ff;
  logic                  rclk_oe_n_ff;
  logic                  lock_n_ff;
  logic                  lock_oe_n_ff;
  logic                  nxt_word_oe_n;
  logic                  nxt_rclk_oe_n;
  logic                  nxt_lock_oe_n;
  logic                  locked;
  logic                  load_word;
  logic [3:0]            bit_cnt;
  sdl_word_t             wd;
  logic                  wr_pend_ff;
  logic [7:0]            wr_addr_ff;
  logic [31:0]           hrdata_ff;
  logic [31:0]           nxt_rdata;
  logic                  bus_take;

  // ****************************************
  // front end
  // ****************************************
  // undriven pair (both equal) reads as zero: framing fails, no false lock
  assign serial_bit = serial_in_pos & ~serial_in_neg;
  assign locked     = (state_ff == SDL_LOCKED);

  sdl_ref_mon u_ref_mon (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ref_in  (local_reference_clock),
    .ref_ok  (ref_ok)
  );

  // sleep holds the aligner cleared, which stops recovery
  sdl_word_align u_align (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .run        (sleep_n), // R2
    .slip       (slip),
    .serial_bit (serial_bit),
    .word       (wd),
    .bit_cnt    (bit_cnt)
  );

  // ****************************************
  // lock search and monitor
  // ****************************************
  // hunting slips one bit per bad frame; random data or sync patterns both
  // converge because the clock bits are the only fixed 1-then-0 pair
  always_comb begin
    nxt_state = state_ff;
    nxt_good  = good_ff;
    nxt_bad   = bad_ff;
    slip      = 1'b0;
    if (!sleep_n || !ref_ok || rehunt_ff) begin // R9
      nxt_state = SDL_HUNT;
      nxt_good  = 4'h0;
      nxt_bad   = 3'h0;
    end else if (wd.strobe) begin
      case (state_ff)
        SDL_HUNT, SDL_CHECK: begin // R13
          if (wd.valid) begin
            nxt_good  = good_ff + 4'h1;
            nxt_state = (nxt_good == LOCK_WORDS) ? SDL_LOCKED : SDL_CHECK;
          end else begin
            nxt_good  = 4'h0;
            nxt_state = SDL_HUNT;
            slip      = 1'b1;
          end
        end
        SDL_LOCKED: begin // R15
          if (wd.valid) begin
            nxt_bad = 3'h0;
          end else if (bad_ff == LOSS_WORDS - 3'h1) begin // R17
            nxt_state = SDL_HUNT;
            nxt_bad   = 3'h0;
            nxt_good  = 4'h0;
          end else begin
            nxt_bad = bad_ff + 3'h1;
          end
        end
        default: begin
          nxt_state = SDL_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= SDL_HUNT;
      good_ff  <= 4'h0;
      bad_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      good_ff  <= nxt_good;
      bad_ff   <= nxt_bad;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loss_cnt_ff <= 16'h0000;
    end else if (locked && nxt_state == SDL_HUNT && loss_cnt_ff != 16'hFFFF) begin
      loss_cnt_ff <= loss_cnt_ff + 16'h0001;
    end
  end

  // ****************************************
  // recovered clock and data
  // ****************************************
  // data moves on the inactive edge so the selected edge sees it settled
  assign load_word = locked && (bit_cnt == (out_edge_select ? HALF_BIT : 4'h0)); // R1

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff  <= '0;
      pword_ff <= '0;
      rclk_ff  <= 1'b0;
    end else begin
      if (wd.strobe && wd.valid) begin
        pend_ff <= wd.data; // R16
      end
      if (load_word) begin
        pword_ff <= pend_ff; // R14
      end
      rclk_ff <= locked && (bit_cnt < HALF_BIT); // R4 R8
    end
  end

  // ****************************************
  // output drive control
  // ****************************************
  // sleep wins over enable; lock pin ignores enable
  always_comb begin
    nxt_lock_oe_n = !sleep_n; // R2 R20
    nxt_word_oe_n = !(sleep_n && out_en_ff && locked); // R5 R6 R10 R20
    nxt_rclk_oe_n = nxt_word_oe_n; // R5 R20
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_oe_n_ff <= 1'b1;
      rclk_oe_n_ff <= 1'b1;
      lock_oe_n_ff <= 1'b1;
      lock_n_ff    <= 1'b1;
    end else begin
      word_oe_n_ff <= nxt_word_oe_n;
      rclk_oe_n_ff <= nxt_rclk_oe_n;
      lock_oe_n_ff <= nxt_lock_oe_n;
      lock_n_ff    <= !locked; // R3 R7
    end
  end

  assign parallel_word_out    = pword_ff;
  assign recovered_clock      = rclk_ff;
  assign word_oe_n            = word_oe_n_ff;
  assign recovered_clock_oe_n = rclk_oe_n_ff;
  assign lock_n               = lock_n_ff;
  assign lock_oe_n            = lock_oe_n_ff;

  // ****************************************
  // register bus
  // ****************************************
  // zero wait states: read data is prepared during the address phase
  assign bus_take = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (haddr[7:0])
      CTRL_OFS: begin
        nxt_rdata[CTRL_OE_BIT] = out_en_ff;
      end
      STATUS_OFS: begin
        nxt_rdata = {6'h00, pend_ff, 11'h000, ref_ok, good_ff[0], state_ff, locked};
      end
      LOSS_OFS: begin
        nxt_rdata = {16'h0000, loss_cnt_ff};
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
    if (haddr[31:8] != 24'h000000) begin
      nxt_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff  <= 32'h0000_0000;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= bus_take && hwrite && (haddr[31:8] == 24'h000000);
      if (bus_take) begin
        wr_addr_ff <= haddr[7:0];
      end
      if (bus_take && !hwrite) begin
        hrdata_ff <= nxt_rdata;
      end
    end
  end

  // rehunt is a one-cycle self-clearing command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_en_ff <= CTRL_OE_RST;
      rehunt_ff <= 1'b0;
    end else begin
      rehunt_ff <= 1'b0;
      if (wr_pend_ff && wr_addr_ff == CTRL_OFS) begin
        out_en_ff <= hwdata[CTRL_OE_BIT];
        rehunt_ff <= hwdata[CTRL_HUNT_BIT];
      end
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_bad_last;
    locked && wd.strobe && !wd.valid && bad_ff == 3'h3;
  endsequence

  sequence s_sleep_ok;
    sleep_n && ref_ok && !rehunt_ff;
  endsequence

  a_sleep_float: assert property (!sleep_n |=> lock_oe_n && word_oe_n && recovered_clock_oe_n) // R2
    else $error("outputs not floated in sleep");
  a_lock_low: assert property (locked |=> !lock_n) // R3
    else $error("lock indicator not low while locked");
  a_unlock_float: assert property (sleep_n && !locked |=> word_oe_n && recovered_clock_oe_n && lock_n && !lock_oe_n) // R6
    else $error("unlocked outputs wrong");
  a_oe_off: assert property (sleep_n && !out_en_ff |=> word_oe_n && recovered_clock_oe_n && !lock_oe_n) // R5
    else $error("enable low did not float data");
  a_ref_gate: assert property (!ref_ok |=> !locked ##1 lock_n) // R9
    else $error("locked without reference");
  a_loss_four: assert property (s_sleep_ok and s_bad_last |=> !locked ##1 lock_n) // R17
    else $error("loss not declared at fourth bad word");
  a_no_early: assert property (s_sleep_ok and (locked && wd.strobe && !wd.valid && bad_ff < 3'h3) |=> locked) // R15
    else $error("loss declared too early");
  a_rclk_gate: assert property (!locked |=> !recovered_clock) // R8
    else $error("clock running while unlocked");
  a_data_edge: assert property ($changed(pword_ff) |-> ($past(out_edge_select) ? !rclk_ff : rclk_ff)) // R1
    else $error("data moved on the active edge");
  a_strip_bits: assert property (wd.strobe && wd.valid |=> pend_ff == $past(wd.data)) // R16
    else $error("data bits not taken from frame");

  // ****************************************
  // recovered clock, drive and lock checks
  // ****************************************
  // a locked word period: clock high from count 1 through count 6
  sequence s_word_start;
    locked && bit_cnt == 4'h0 ##1 locked [*5];
  endsequence

  sequence s_lock_drop;
    locked && nxt_state == SDL_HUNT && loss_cnt_ff != 16'hFFFF;
  endsequence

  a_rclk_rise: assert property (s_word_start |=> recovered_clock) // R4
    else $error("recovered clock low in first half of word");
  a_rclk_fall: assert property (locked && bit_cnt == HALF_BIT |=> !recovered_clock) // R4 R8
    else $error("recovered clock high in second half of word");
  a_lock_live: assert property (sleep_n && !out_en_ff |=> lock_n == !$past(locked)) // R7
    else $error("lock indicator frozen while outputs disabled");
  a_float_lock: assert property (!locked |=> word_oe_n && recovered_clock_oe_n) // R10
    else $error("outputs driven before lock");
  a_sleep_hunt: assert property (!sleep_n |=> !locked && bit_cnt == 4'h0) // R2
    else $error("recovery still running in sleep");
  a_lock_count: assert property ($rose(locked) |-> $past(good_ff) == LOCK_WORDS - 4'h1) // R13
    else $error("lock declared without enough good words");
  a_hunt_reset: assert property (!locked && wd.strobe && !wd.valid |=> good_ff == 4'h0) // R13
    else $error("good word count kept after bad frame");
  a_word_hold: assert property (!load_word |=> $stable(pword_ff)) // R14
    else $error("output word moved outside its load slot");
  a_lock_drive: assert property (sleep_n |=> !lock_oe_n) // R20
    else $error("lock indicator floated while awake");
  a_data_drive: assert property (sleep_n && out_en_ff && locked |=> !word_oe_n && !recovered_clock_oe_n) // R20
    else $error("data not driven while locked and enabled");
  a_loss_count: assert property (s_lock_drop |=> loss_cnt_ff == $past(loss_cnt_ff) + 16'h0001) // R15
    else $error("lock loss not counted");
  a_rehunt_drop: assert property (rehunt_ff |=> !locked) // R15
    else $error("lock kept after search command");

endmodule

// >>> verilog/sdl_pkg.sv
// Function
// [R1] edge select picks rising or falling strobe
// [R2] sleep stops recovery, floats every output
// [R3] lock indicator low once locked
// [R4] recovered word-rate clock strobes data
// [R5] output enable low floats data, clock
// [R6] unlocked: data, clock float; lock high
// [R7] lock indicator live while outputs disabled
// [R8] recovered clock runs only while locked
// [R9] no lock without running reference clock
// [R10] outputs float until stream locked
// [R11] serializer sends sync while request high
// [R12] lock indicator feeds serializer request input
// [R13] random data lock without sync patterns
// [R14] data valid while lock indicator low
// [R15] keep monitoring; lock high on loss
// [R16] strip two clock bits, output ten
// [R17] loss after four bad words running
// [R18] three words before loss are suspect
// [R19] sync request sends at least 1024 symbols
// [R20] float controls from sleep, enable, lock
package sdl_pkg;

  // ****************************************
  // framing
  // ****************************************
  localparam int          WORD_BITS   = 10;
  localparam int          FRAME_BITS  = WORD_BITS + 2;
  localparam logic [3:0]  LAST_BIT    = 4'hB;
  localparam logic [3:0]  HALF_BIT    = 4'h6;
  localparam logic [2:0]  LOSS_WORDS  = 3'h4;
  localparam logic [3:0]  LOCK_WORDS  = 4'h8;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          REF_TIMEOUT_NS = 1000;
  localparam int          REF_TIMEOUT_CYC = REF_TIMEOUT_NS / CLK_PERIOD_NS;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam logic [7:0]  LOSS_OFS    = 8'h08;
  localparam int          CTRL_OE_BIT = 0;
  localparam int          CTRL_HUNT_BIT = 1;
  localparam logic        CTRL_OE_RST = 1'b1;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;

  typedef struct packed {
    logic                 strobe;
    logic                 valid;
    logic [WORD_BITS-1:0] data;
  } sdl_word_t;

  typedef enum logic [1:0] {SDL_HUNT, SDL_CHECK, SDL_LOCKED} sdl_state_t;

endpackage

// >>> verilog/sdl_ref_mon.sv
`timescale 1ns/100ps
module sdl_ref_mon
  import sdl_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // reference
  input  wire logic ref_in,
  output logic      ref_ok
);

  logic       ref_prev_ff;
  logic [7:0] idle_ff;

  // a stopped reference in either level times out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_prev_ff <= 1'b0;
      idle_ff     <= 8'hFF;
    end else begin
      ref_prev_ff <= ref_in;
      if (ref_in != ref_prev_ff) begin
        idle_ff <= 8'h00;
      end else if (idle_ff != 8'hFF) begin
        idle_ff <= idle_ff + 8'h01;
      end
    end
  end

  assign ref_ok = (idle_ff < 8'(REF_TIMEOUT_CYC));

endmodule

// >>> verilog/sdl_word_align.sv
`timescale 1ns/100ps
module sdl_word_align
  import sdl_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       run,
  input  wire logic       slip,
  input  wire logic       serial_bit,
  // word out
  output sdl_word_t       word,
  output logic [3:0]      bit_cnt
);

  logic [FRAME_BITS-2:0] shift_ff;
  logic [3:0]            cnt_ff;
  sdl_word_t             word_ff;

  // slip holds the count one bit to walk the frame boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_ff <= '0;
      cnt_ff   <= 4'h0;
      word_ff  <= '0;
    end else begin
      shift_ff       <= run ? {shift_ff[FRAME_BITS-3:0], serial_bit} : '0;
      word_ff.strobe <= run && (cnt_ff == LAST_BIT) && !slip;
      word_ff.valid  <= shift_ff[FRAME_BITS-2] && !serial_bit;
      word_ff.data   <= shift_ff[WORD_BITS-1:0];
      if (!run) begin
        cnt_ff <= 4'h0;
      end else if (slip) begin
        cnt_ff <= cnt_ff;
      end else if (cnt_ff == LAST_BIT) begin
        cnt_ff <= 4'h0;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  assign word    = word_ff;
  assign bit_cnt = cnt_ff;

endmodule
